//--- include/seq_pkg.sv
// Constants, field layouts and types of the step-speed sequencer.
// Assumes a single 10 MHz core clock.
package seq_pkg;
  localparam int CLK_HZ        = 10_000_000;
  localparam int TENTH_SEC_MS  = 100;
  localparam int TENTH_MIN_MS  = 6000;
  localparam int TENTH_SEC_CYC = CLK_HZ / 1000 * TENTH_SEC_MS;
  localparam int TENTH_MIN_CYC = CLK_HZ / 1000 * TENTH_MIN_MS;

  localparam int NUM_STEPS = 16;
  localparam logic [3:0] LAST_STEP = 4'hF;
  localparam logic signed [15:0] SP_MAX = 16'sh03E8;
  localparam logic signed [15:0] SP_MIN = -16'sh03E8;
  localparam logic [25:0] PCT_FULL = 26'h00003E8;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_MAXF   = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_OUTF   = 8'h0C;
  localparam logic [7:0] OFS_SNAP   = 8'h10;
  localparam logic [7:0] OFS_RESUME = 8'h14;

  localparam int ST_RUN_BIT    = 4;
  localparam int ST_DONE_BIT   = 5;
  localparam int ST_SNAP_BIT   = 6;
  localparam int ST_REV_BIT    = 7;
  localparam int RES_VALID_BIT = 4;
  localparam int SNAP_FREQ_LSB = 15;

  localparam logic [1:0] MODE_ONCE = 2'h0;
  localparam logic [1:0] MODE_HOLD = 2'h1;
  localparam logic [1:0] MODE_LOOP = 2'h2;

  typedef struct packed {
    logic       seq_sel;
    logic       run_cmd;
    logic       run_chan;
    logic       unit_min;
    logic       retain;
    logic [1:0] run_mode;
  } ctrl_type;

  localparam ctrl_type CTRL_RST = 7'h00;
  localparam logic [15:0] MAXF_RST = 16'h1388;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_RUN  = 4'b0010,
    S_HOLD = 4'b0100,
    S_DONE = 4'b1000
  } seq_state_type;
endpackage

//--- core/tenth_tick.sv
// Tenth-of-a-unit time base for step durations.
// Assumes restart is a synchronous one-cycle or level request.
`timescale 1ns/1ps
module tenth_tick
  import seq_pkg::*;
#(
  parameter int SEC_CYC = TENTH_SEC_CYC,
  parameter int MIN_CYC = TENTH_MIN_CYC
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic unit_min,
  input  wire logic restart,
  output logic      tick
);
  localparam int CW = $clog2(MIN_CYC + 1);
  logic [CW-1:0] cnt_r;
  wire  [CW-1:0] lim = unit_min ? CW'(MIN_CYC - 1) : CW'(SEC_CYC - 1);

  // Restart keeps every step's first tenth a full tenth
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (restart || cnt_r >= lim) begin
      cnt_r <= '0;
      tick  <= !restart;
    end else begin
      cnt_r <= cnt_r + CW'(1);
      tick  <= 1'b0;
    end
  end
endmodule

//--- core/step_sequencer.sv
// Step-speed sequencer with Avalon-MM register slave.
// Assumes synchronous pins and a master honouring waitrequest.
`timescale 1ns/1ps
module step_sequencer
  import seq_pkg::*;
#(
  parameter int SEC_CYC = TENTH_SEC_CYC,
  parameter int MIN_CYC = TENTH_MIN_CYC
) (
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic [7:0]         address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [31:0]        writedata,
  input  wire logic [3:0]         byteenable,
  output logic [31:0]             readdata,
  output logic                    waitrequest,
  input  wire logic               term_run,
  input  wire logic [3:0]         step_sel,
  input  wire logic signed [16:0] normal_freq,
  input  wire logic               power_fail,
  output logic signed [16:0]      freq_ref_r,
  output logic                    dir_reverse_r,
  output logic                    running_r
);
  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] m;
    m = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) m[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return m;
  endfunction

  function automatic logic signed [15:0] clamp_sp(input logic [15:0] v);
    logic signed [15:0] s;
    s = $signed(v);
    if (s > SP_MAX) return SP_MAX;
    else if (s < SP_MIN) return SP_MIN;
    else return s;
  endfunction

  // Percent in tenths times max frequency, sign kept for direction
  function automatic logic signed [16:0] scale(input logic signed [15:0] sp,
                                               input logic [15:0] maxf);
    logic [15:0] mag;
    logic [25:0] prod;
    logic [16:0] f;
    mag  = sp[15] ? 16'(-sp) : 16'(sp);
    prod = 26'(mag) * 26'(maxf);
    f    = 17'(prod / PCT_FULL);
    return sp[15] ? -$signed(f) : $signed(f);
  endfunction

  logic signed [15:0] freq_mem [NUM_STEPS];
  logic [15:0]        dur_mem  [NUM_STEPS];
  ctrl_type           ctrl_r;
  logic [15:0]        maxf_r;
  seq_state_type      state_r, state_nxt;
  logic [3:0]         step_r, step_nxt;
  logic [15:0]        elapsed_r, elapsed_nxt;
  logic [3:0]         snap_step_r, resume_step_r;
  logic signed [16:0] snap_freq_r;
  logic               snap_valid_r, resume_valid_r, pf_d_r;
  logic               tick;

  // Bus decode
  wire        wr_en     = write && !waitrequest;
  wire        step_hit  = address[7];
  wire [3:0]  step_idx  = address[6:3];
  wire        step_dur  = address[2];
  wire [31:0] step_word = step_dur ? {16'h0000, dur_mem[step_idx]}
                                   : {16'h0000, freq_mem[step_idx]};
  wire [31:0] wdat_step = merge_be(step_word, writedata, byteenable);
  wire [31:0] wdat_ctrl = merge_be({25'h0, ctrl_r}, writedata, byteenable);
  wire [31:0] wdat_maxf = merge_be({16'h0, maxf_r}, writedata, byteenable);
  wire [31:0] wdat_res  = merge_be({27'h0, resume_valid_r, resume_step_r},
                                   writedata, byteenable);
  wire        wr_step   = wr_en && step_hit;
  wire        wr_ctrl   = wr_en && address == OFS_CTRL;
  wire        wr_maxf   = wr_en && address == OFS_MAXF;
  wire        wr_res    = wr_en && address == OFS_RESUME;
  wire        clr_snap  = wr_en && address == OFS_STATUS &&
                          byteenable[0] && writedata[ST_SNAP_BIT];

  wire [31:0] status_word = {24'h0, dir_reverse_r, snap_valid_r,
                             state_r == S_DONE, running_r, step_r};
  wire [31:0] rd_word =
    step_hit                ? step_word :
    address == OFS_CTRL     ? {25'h0, ctrl_r} :
    address == OFS_MAXF     ? {16'h0, maxf_r} :
    address == OFS_STATUS   ? status_word :
    address == OFS_OUTF     ? 32'(freq_ref_r) :
    address == OFS_SNAP     ? {snap_freq_r, 11'h000, snap_step_r} :
    address == OFS_RESUME   ? {27'h0, resume_valid_r, resume_step_r} :
                              32'h0000_0000;

  // One wait cycle, then a single-cycle answer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else begin
      waitrequest <= waitrequest ? !(read || write) : 1'b1;
      if (waitrequest && read) readdata <= rd_word;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_STEPS; i++) begin
        freq_mem[i] <= 16'sh0000;
        dur_mem[i]  <= 16'h0000;
      end
    end else if (wr_step) begin
      if (step_dur) dur_mem[step_idx] <= wdat_step[15:0];
      else freq_mem[step_idx] <= clamp_sp(wdat_step[15:0]);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
      maxf_r <= MAXF_RST;
    end else begin
      if (wr_ctrl) ctrl_r <= wdat_ctrl[6:0];
      if (wr_maxf) maxf_r <= wdat_maxf[15:0];
    end
  end

  // Sequencer
  wire run_req   = ctrl_r.run_chan ? term_run : ctrl_r.run_cmd;
  wire step_done = elapsed_r >= dur_mem[step_r];
  wire resume_ok = ctrl_r.retain && resume_valid_r;
  wire [3:0] start_step = resume_ok ? resume_step_r : 4'h0;
  wire start     = state_r == S_IDLE && run_req;
  wire restart   = state_r != S_RUN || step_done;

  always_comb begin
    state_nxt   = state_r;
    step_nxt    = step_r;
    elapsed_nxt = elapsed_r;
    case (state_r)
      S_IDLE: begin
        if (run_req) begin
          state_nxt   = S_RUN;
          step_nxt    = start_step;
          elapsed_nxt = 16'h0000;
        end
      end
      S_RUN: begin
        if (!run_req) begin
          state_nxt = S_IDLE;
        end else if (step_done) begin
          elapsed_nxt = 16'h0000;
          if (step_r == LAST_STEP) begin
            case (ctrl_r.run_mode)
              MODE_LOOP: step_nxt  = 4'h0;
              MODE_HOLD: state_nxt = S_HOLD;
              default:   state_nxt = S_DONE;
            endcase
          end else begin
            step_nxt = step_r + 4'h1;
          end
        end else if (tick) begin
          elapsed_nxt = elapsed_r + 16'h0001;
        end
      end
      S_HOLD, S_DONE: begin
        if (!run_req) state_nxt = S_IDLE;
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= S_IDLE;
      step_r    <= 4'h0;
      elapsed_r <= 16'h0000;
    end else begin
      state_r   <= state_nxt;
      step_r    <= step_nxt;
      elapsed_r <= elapsed_nxt;
    end
  end

  tenth_tick #(
    .SEC_CYC (SEC_CYC),
    .MIN_CYC (MIN_CYC)
  ) u_tick (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .unit_min (ctrl_r.unit_min),
    .restart  (restart),
    .tick     (tick)
  );

  // Reference selection
  wire seq_out = state_r == S_RUN || state_r == S_HOLD;
  wire signed [15:0] seq_sp    = freq_mem[step_r];
  wire signed [16:0] seq_freq  = scale(seq_sp, maxf_r);
  wire signed [16:0] term_freq = scale(freq_mem[step_sel], maxf_r);
  wire signed [16:0] freq_nxt  =
    |step_sel      ? term_freq :
    ctrl_r.seq_sel ? (seq_out ? seq_freq : 17'sh00000) :
                     normal_freq;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      freq_ref_r    <= 17'sh00000;
      dir_reverse_r <= 1'b0;
      running_r     <= 1'b0;
    end else begin
      freq_ref_r    <= freq_nxt;
      dir_reverse_r <= freq_nxt < 0;
      running_r     <= seq_out;
    end
  end

  // Power-loss snapshot; software keeps it and writes it back to resume
  wire snap_set = power_fail && !pf_d_r && ctrl_r.retain;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pf_d_r         <= 1'b0;
      snap_valid_r   <= 1'b0;
      snap_step_r    <= 4'h0;
      snap_freq_r    <= 17'sh00000;
      resume_valid_r <= 1'b0;
      resume_step_r  <= 4'h0;
    end else begin
      pf_d_r       <= power_fail;
      snap_valid_r <= snap_set || (snap_valid_r && !clr_snap);
      // Next reference, so step and frequency come from the same cycle
      if (snap_set) begin
        snap_step_r <= step_r;
        snap_freq_r <= freq_nxt;
      end
      // Software arming wins over the consume at start
      if (wr_res) begin
        resume_valid_r <= wdat_res[RES_VALID_BIT];
        resume_step_r  <= wdat_res[3:0];
      end else if (start && resume_ok) begin
        resume_valid_r <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  wire at_end = state_r == S_RUN && run_req && step_done &&
                step_r == LAST_STEP;

  a_once_stops: assert property (at_end && ctrl_r.run_mode == MODE_ONCE
    |=> state_r == S_DONE ##1 !running_r)
    else $error("once mode did not stop");
  a_hold_last: assert property (at_end && ctrl_r.run_mode == MODE_HOLD
    |=> state_r == S_HOLD && step_r == LAST_STEP)
    else $error("hold mode left last step");
  a_loop_wrap: assert property (at_end && ctrl_r.run_mode == MODE_LOOP
    |=> state_r == S_RUN && step_r == 4'h0)
    else $error("loop mode did not wrap");
  a_resume_step: assert property (start
    |=> step_r == $past(start_step) && elapsed_r == 16'h0000)
    else $error("wrong start step");
  a_sp_range: assert property (seq_sp <= SP_MAX && seq_sp >= SP_MIN)
    else $error("setpoint out of range");
  a_tick_count: assert property (state_r == S_RUN && run_req && !step_done
    && tick |=> elapsed_r == $past(elapsed_r) + 16'h0001)
    else $error("elapsed time not counted");
  a_step_ascend: assert property (state_r == S_RUN && run_req && step_done
    && step_r != LAST_STEP |=> step_r == $past(step_r) + 4'h1)
    else $error("step did not advance");
  a_dir_sign: assert property (##1 dir_reverse_r == freq_ref_r[16])
    else $error("direction disagrees with sign");
  a_stop_cmd: assert property (!run_req && state_r != S_IDLE
    |=> state_r == S_IDLE ##1 !running_r)
    else $error("stop command ignored");
  a_term_prio: assert property (|step_sel
    |=> freq_ref_r == $past(term_freq))
    else $error("terminal step not selected");

  c_loop_wrap: cover property (at_end && ctrl_r.run_mode == MODE_LOOP);
  c_hold_enter: cover property (state_r == S_RUN ##1 state_r == S_HOLD);
  c_done_enter: cover property (state_r == S_RUN ##1 state_r == S_DONE);
  c_resume: cover property (start && resume_ok);
endmodule

//--- verification/motor_core_model.sv
// Behavioural motor-control core that consumes the speed reference.
// Assumes the reference, direction and running flags share core_clk.
`timescale 1ns/1ps
module motor_core_model (
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic signed [16:0] freq_ref,
  input  wire logic               dir_reverse,
  input  wire logic               running,
  output logic signed [16:0]      speed_r,
  output logic                    dir_fault_r
);
  // Zero reference carries no direction, so it is never judged
  wire dir_bad = running && freq_ref != 17'sh0
                 && dir_reverse != (freq_ref < 17'sh0);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      speed_r     <= 17'sh0;
      dir_fault_r <= 1'b0;
    end else begin
      speed_r     <= freq_ref;
      dir_fault_r <= dir_fault_r | dir_bad;
    end
  end
endmodule

//--- verification/multi_step_speed_sequencer_tb.sv
// Self-checking bench for the step-speed sequencer.
// Assumes short tick counts (10 and 20 cycles) and a 10 MHz clock.
`timescale 1ns/1ps
module multi_step_speed_sequencer_tb;
  import seq_pkg::*;
  logic               core_clk    = 1'b0;
  logic               rst_n       = 1'b0;
  logic               read        = 1'b0;
  logic               write       = 1'b0;
  logic               term_run    = 1'b0;
  logic               power_fail  = 1'b0;
  logic [7:0]         address     = 8'h00;
  logic [31:0]        writedata   = 32'h00000000;
  logic [3:0]         byteenable  = 4'hF;
  logic [3:0]         step_sel    = 4'h0;
  logic signed [16:0] normal_freq = 17'sh0;
  logic [31:0]        readdata, rd, seed;
  logic               waitrequest, dir_reverse_r, running_r, dir_fault;
  logic signed [16:0] freq_ref_r, speed;
  logic signed [15:0] sp [16];
  int                 bad_count, samples_checked, cycles, maxf;
  int                 last, wraps, runs, s;
  int                 tcyc = 10;
  int                 dur [16];

  step_sequencer #(.SEC_CYC(10), .MIN_CYC(20)) DUT (.core_clk, .rst_n,
    .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest, .term_run, .step_sel, .normal_freq, .power_fail,
    .freq_ref_r, .dir_reverse_r, .running_r);
  motor_core_model partner (.core_clk, .rst_n, .freq_ref(freq_ref_r),
    .dir_reverse(dir_reverse_r), .running(running_r), .speed_r(speed),
    .dir_fault_r(dir_fault));

  always #50 core_clk = ~core_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Truncation follows the magnitude, so negative steps round to zero
  function automatic logic signed [16:0] scale(input int v);
    int m;
    m = (v < 0 ? -v : v) * maxf / 1000;
    return 17'(v < 0 ? -m : m);
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checked=%0d bad=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One edge between requests keeps release and raise apart
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    address   <= a;
    writedata <= d;
    write     <= wr;
    read      <= !wr;
    // Only the bench timeout ends a wait that never gets an answer
    do begin
      @(posedge core_clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read  <= 1'b0;
  endtask

  task automatic watch(input int start, input int cyc);
    logic first, prev;
    int   dwell, lo;
    last  = start;
    first = 1;
    prev  = 0;
    wraps = 0;
    runs  = 0;
    dwell = 0;
    repeat (cyc) begin
      @(posedge core_clk);
      if (running_r === 1'b1) begin
        if (!prev) runs++;
        if (!first && freq_ref_r !== scale(sp[last]) &&
            freq_ref_r === scale(sp[(last + 1) % 16])) begin
          // Tick latency and the advance decision may add two cycles
          lo = tcyc * dur[last];
          check(dwell >= lo && dwell <= lo + 2, 1);
          last  = (last + 1) % 16;
          dwell = 0;
          if (last == 0) wraps++;
        end
        dwell++;
        check(freq_ref_r, scale(sp[last]));
        check(dir_reverse_r, sp[last] < 0);
        first = 0;
      end
      prev = running_r === 1'b1;
    end
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      finish_test();
    end
  end

  initial begin
    seed = 32'h65E609A8;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    bus(0, OFS_CTRL, 0); check(rd, 32'h00000000);
    bus(0, OFS_MAXF, 0); check(rd, {16'h0000, MAXF_RST});
    bus(0, 8'h40, 0); check(rd, 32'h00000000);
    bus(1, 8'h98, 32'h000007D0);
    bus(0, 8'h98, 0); check(rd, 32'h000003E8);
    bus(1, 8'h98, 32'h0000F830);
    bus(0, 8'h98, 0); check(rd, 32'h0000FC18);
    bus(1, 8'hFC, 32'h0000FFFF);
    bus(0, 8'hFC, 0); check(rd, 32'h0000FFFF);
    maxf = 2999;
    bus(1, OFS_MAXF, 32'h00000BB7);
    // Distinct magnitudes let the watcher tell steps apart
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      sp[i] = 16'((seed % 60) * 16 + i);
      if (seed[8]) sp[i] = -sp[i];
      dur[i] = i == 0 ? 0 : int'(seed[13:12]);
      bus(1, 8'(8'h80 + 8 * i), 32'(sp[i]));
      bus(1, 8'(8'h84 + 8 * i), 32'(dur[i]));
      bus(0, 8'(8'h80 + 8 * i), 0); check(rd, {16'h0000, sp[i]});
      bus(0, 8'(8'h84 + 8 * i), 0);
      check(rd, 32'(dur[i]));
    end
    for (int k = 1; k < 16; k += 3) begin
      @(posedge core_clk);
      step_sel <= 4'(k);
      repeat (3) @(posedge core_clk);
      check(freq_ref_r, scale(sp[k]));
    end
    seed = lfsr(seed);
    step_sel    <= 4'h0;
    normal_freq <= 17'(seed[15:0]) - 17'sh8000;
    repeat (3) @(posedge core_clk);
    check(freq_ref_r, normal_freq);
    bus(0, OFS_OUTF, 0); check(rd, 32'(normal_freq));
    // Mode 3 must behave as mode 0
    for (int m = 0; m < 4; m++) begin
      bus(1, OFS_CTRL, 32'h60 | m);
      watch(0, 800);
      if (m == 0 || m == 3) begin
        check(runs, 1);
        check(running_r, 0);
        check(freq_ref_r, 0);
        bus(0, OFS_STATUS, 0); check(rd[5], 1);
      end else if (m == 1) begin
        check(last, 15);
        check(wraps, 0);
        check(running_r, 1);
      end else
        check(wraps > 0, 1);
      bus(1, OFS_CTRL, 32'h40);
      repeat (4) @(posedge core_clk);
      check(running_r, 0);
    end
    // Minute unit from here on, so steps tick at the slower rate
    tcyc = 20;
    bus(1, OFS_CTRL, 32'h5D);
    term_run <= 1'b1;
    watch(0, 150);
    check(runs, 1);
    power_fail <= 1'b1;
    repeat (3) @(posedge core_clk);
    bus(0, OFS_SNAP, 0);
    s = rd[3:0];
    check($signed(rd[31:15]), scale(sp[s]));
    bus(0, OFS_STATUS, 0); check(rd[6], 1);
    bus(1, OFS_STATUS, 32'h00000040);
    bus(0, OFS_STATUS, 0); check(rd[6], 0);
    term_run   <= 1'b0;
    power_fail <= 1'b0;
    repeat (4) @(posedge core_clk);
    check(running_r, 0);
    bus(1, OFS_RESUME, 32'h10 | s);
    term_run <= 1'b1;
    watch(s, 20);
    term_run <= 1'b0;
    bus(1, OFS_CTRL, 32'h59);
    bus(1, OFS_RESUME, 32'h10 | s);
    term_run <= 1'b1;
    watch(0, 20);
    check(dir_fault, 0);
    finish_test();
  end
endmodule
